// [ett_defines.svh]
// Summary of operation
// - eight-bit up-counter with pre-load register
// - two bits select one of four sources
// - load pulse copies pre-load into counter
// - counter write copies pre-load into counter
// - pre-load readable, writable, buffered
// - counts on selected source tick while enabled
// - start detect: idle until start edge
// - first interval end samples serial input
// - carry-out clocks receive and transmit latches
// - software feeds bits, carry times output
// - pins one and two shared with timer
// - aux clock slower, master is multiple
`ifndef ETT_DEFINES_SVH
`define ETT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define ETT_OFS_CTRL     8'h00
`define ETT_OFS_PRELOAD  8'h04
`define ETT_OFS_COUNT    8'h08
`define ETT_OFS_SERIAL   8'h0C
`define ETT_OFS_GPIO     8'h10

////////////////////////////////////////////////////////////////////////////////
// control fields
`define ETT_CTRL_SEL_LO  0
`define ETT_CTRL_SEL_HI  1
`define ETT_CTRL_EN      2
`define ETT_CTRL_START   3
`define ETT_CTRL_TXPIN   4
`define ETT_CTRL_LOAD    5
`define ETT_CTRL_WAIT    6

// serial fields
`define ETT_SER_RX       0
`define ETT_SER_TX       1
`define ETT_SER_CARRY    2

// port fields
`define ETT_GPIO_OUT_LO  0
`define ETT_GPIO_OUT_HI  1
`define ETT_GPIO_DIR_LO  2
`define ETT_GPIO_DIR_HI  3
`define ETT_GPIO_IN_LO   4
`define ETT_GPIO_IN_HI   5

////////////////////////////////////////////////////////////////////////////////
// reset values, count top and count step
`define ETT_RST_BYTE     8'h00
`define ETT_RST_MARK     1'b1
`define ETT_CNT_TOP      8'hFF
`define ETT_CNT_STEP     8'h01

`endif

// [ett_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module ett_edge
   import ett_pkg::*;
#(
   parameter bit FALLING = 1'b0,
   parameter bit IDLE    = 1'b0
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic level,
   output logic      edge_pulse
);
   logic prev;

   // idle value avoids a false edge straight after reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         prev <= IDLE;
      end else begin
         prev <= level;
      end
   end

   assign edge_pulse = FALLING ? (prev & ~level) : (~prev & level);
endmodule // ett_edge
`default_nettype wire

// [ett_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module ett_peer (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        go,
   input  wire logic        pulse_mode,
   input  wire logic [7:0]  data,
   input  wire logic [15:0] period,
   output logic             busy,
   output logic             drive,
   output logic             level
);
   int i;
   initial begin
      busy  = 1'b0;
      drive = 1'b0;
      level = 1'b1;
   end
   always @(posedge clock) begin
      if (rst_b && go && !busy) begin
         busy  <= 1'b1;
         drive <= 1'b1;
         if (pulse_mode) begin
            // low then high, so each pulse gives one rising edge
            for (i = 0; i < data; i++) begin
               level <= 1'b0;
               repeat (4) @(posedge clock);
               level <= 1'b1;
               repeat (4) @(posedge clock);
            end
         end else begin
            // start bit spans one and a half intervals, so each carry after the first lands mid-bit
            level <= 1'b0;
            repeat (period + period / 2) @(posedge clock);
            for (i = 0; i < 8; i++) begin
               level <= data[i];
               repeat (period) @(posedge clock);
            end
            level <= 1'b1;
            repeat (period) @(posedge clock);
         end
         // released line floats to the pull-up level
         drive <= 1'b0;
         busy  <= 1'b0;
      end
   end
endmodule // ett_peer
`default_nettype wire

// [ett_pkg.sv]
package ett_pkg;
   typedef enum logic [1:0] {ETT_SRC_MASTER, ETT_SRC_AUX, ETT_SRC_PIN, ETT_SRC_GATED} ett_src_e;
   typedef enum logic [1:0] {ETT_FREE, ETT_WAIT, ETT_RUN} ett_state_e;
   typedef logic [7:0] ett_byte_t;
endpackage

// [ett_timer.sv]
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ett_defines.svh"
module ett_timer
   import ett_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        aux_clock,
   input  wire logic        pin1_in,
   output logic             pin1_out,
   output logic             pin1_oe_b,
   input  wire logic        pin2_in,
   output logic             pin2_out,
   output logic             pin2_oe_b
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic       req;
   logic       wr;
   logic       wr_ctrl;
   logic       wr_pre;
   logic       wr_cnt;
   logic       wr_ser;
   logic       wr_gpio;
   ett_src_e   clk_sel;
   logic       count_en;
   logic       start_en;
   logic       tx_pin_func;
   logic       load_pulse;
   logic       load_any;
   ett_byte_t  preload;
   ett_byte_t  count;
   ett_state_e state;
   logic       tick;
   logic       counting;
   logic       carry;
   logic       receive_bit_latch;
   logic       transmit_bit_latch;
   logic       tx_pending;
   logic       carry_flag;
   logic [1:0] gpio_out;
   logic [1:0] gpio_dir;
   logic       aux_rise;
   logic       pin_rise;
   logic       start_edge;
   logic       timer_input_pin;
   logic [31:0] next_rdata;

   assign timer_input_pin = pin1_in;

   ////////////////////////////////////////////////////////////////////////////
   // wishbone slave, one wait state, ack for one cycle
   assign req = wb_cyc_i & wb_stb_i;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   // writes land on the edge that samples ack
   assign wr      = req & wb_ack_o & wb_we_i & wb_sel_i[0];
   assign wr_ctrl = wr & (wb_adr_i == `ETT_OFS_CTRL);
   assign wr_pre  = wr & (wb_adr_i == `ETT_OFS_PRELOAD);
   assign wr_cnt  = wr & (wb_adr_i == `ETT_OFS_COUNT);
   assign wr_ser  = wr & (wb_adr_i == `ETT_OFS_SERIAL);
   assign wr_gpio = wr & (wb_adr_i == `ETT_OFS_GPIO);

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         `ETT_OFS_CTRL: begin
            next_rdata[`ETT_CTRL_SEL_HI:`ETT_CTRL_SEL_LO] = clk_sel;
            next_rdata[`ETT_CTRL_EN]    = count_en;
            next_rdata[`ETT_CTRL_START] = start_en;
            next_rdata[`ETT_CTRL_TXPIN] = tx_pin_func;
            next_rdata[`ETT_CTRL_WAIT]  = (state == ETT_WAIT);
         end
         `ETT_OFS_PRELOAD: begin
            next_rdata[7:0] = preload;
         end
         `ETT_OFS_COUNT: begin
            next_rdata[7:0] = count;
         end
         `ETT_OFS_SERIAL: begin
            next_rdata[`ETT_SER_RX]    = receive_bit_latch;
            next_rdata[`ETT_SER_TX]    = transmit_bit_latch;
            next_rdata[`ETT_SER_CARRY] = carry_flag;
         end
         `ETT_OFS_GPIO: begin
            next_rdata[`ETT_GPIO_OUT_HI:`ETT_GPIO_OUT_LO] = gpio_out;
            next_rdata[`ETT_GPIO_DIR_HI:`ETT_GPIO_DIR_LO] = gpio_dir;
            next_rdata[`ETT_GPIO_IN_HI:`ETT_GPIO_IN_LO]   = {pin2_in, pin1_in};
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req & ~wb_ack_o) begin
         wb_dat_o <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         clk_sel     <= ETT_SRC_MASTER;
         count_en    <= 1'b0;
         start_en    <= 1'b0;
         tx_pin_func <= 1'b0;
      end else if (wr_ctrl) begin
         clk_sel     <= ett_src_e'(wb_dat_i[`ETT_CTRL_SEL_HI:`ETT_CTRL_SEL_LO]);
         count_en    <= wb_dat_i[`ETT_CTRL_EN];
         start_en    <= wb_dat_i[`ETT_CTRL_START];
         tx_pin_func <= wb_dat_i[`ETT_CTRL_TXPIN];
      end
   end

   assign load_pulse = wr_ctrl & wb_dat_i[`ETT_CTRL_LOAD];
   assign load_any   = load_pulse | wr_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // pre-load buffer
   // buffered pre-load write
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         preload <= `ETT_RST_BYTE;
      end else if (wr_pre) begin
         preload <= wb_dat_i[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source selection
   ett_edge #(
      .FALLING (1'b0),
      .IDLE    (1'b0)
   ) u_aux_edge (
      .clock      (clock),
      .rst_b      (rst_b),
      .level      (aux_clock),
      .edge_pulse (aux_rise)
   );

   // pin idles high under its pull-up, so no false rise after reset
   ett_edge #(
      .FALLING (1'b0),
      .IDLE    (1'b1)
   ) u_pin_edge (
      .clock      (clock),
      .rst_b      (rst_b),
      .level      (timer_input_pin),
      .edge_pulse (pin_rise)
   );

   // serial line idles high, start bit is a fall
   ett_edge #(
      .FALLING (1'b1),
      .IDLE    (1'b1)
   ) u_start_edge (
      .clock      (clock),
      .rst_b      (rst_b),
      .level      (timer_input_pin),
      .edge_pulse (start_edge)
   );

   always_comb begin
      case (clk_sel)
         ETT_SRC_MASTER: tick = 1'b1;
         ETT_SRC_AUX:    tick = aux_rise;
         ETT_SRC_PIN:    tick = pin_rise;
         ETT_SRC_GATED:  tick = timer_input_pin;
         default:        tick = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // start-bit state
   // wait for start edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= ETT_FREE;
      end else if (wr_ctrl) begin
         state <= wb_dat_i[`ETT_CTRL_START] ? ETT_WAIT : ETT_FREE;
      end else begin
         case (state)
            ETT_FREE: state <= ETT_FREE;
            ETT_WAIT: state <= start_edge ? ETT_RUN : ETT_WAIT;
            ETT_RUN:  state <= ETT_RUN;
            default:  state <= ETT_FREE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter
   assign counting = count_en & (state != ETT_WAIT) & tick;
   assign carry    = counting & ~load_any & (count == `ETT_CNT_TOP);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count <= `ETT_RST_BYTE;
      end else if (load_any) begin
         count <= preload;
      end else if (carry) begin
         count <= preload;
      end else if (counting) begin
         count <= count + `ETT_CNT_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial latches
   // carry clocks latches
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         receive_bit_latch <= `ETT_RST_MARK;
      end else if (carry) begin
         receive_bit_latch <= timer_input_pin;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tx_pending <= `ETT_RST_MARK;
      end else if (wr_ser) begin
         tx_pending <= wb_dat_i[`ETT_SER_TX];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         transmit_bit_latch <= `ETT_RST_MARK;
      end else if (carry) begin
         transmit_bit_latch <= tx_pending;
      end
   end

   // sticky, set beats a same-cycle clear
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         carry_flag <= 1'b0;
      end else if (carry) begin
         carry_flag <= 1'b1;
      end else if (wr_ser & wb_dat_i[`ETT_SER_CARRY]) begin
         carry_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared port pins
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gpio_out <= 2'h0;
         gpio_dir <= 2'h0;
      end else if (wr_gpio) begin
         gpio_out <= wb_dat_i[`ETT_GPIO_OUT_HI:`ETT_GPIO_OUT_LO];
         gpio_dir <= wb_dat_i[`ETT_GPIO_DIR_HI:`ETT_GPIO_DIR_LO];
      end
   end

   // pin sharing with timer
   // registered pins lag the latch by one cycle, 40 ns against a bit time
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pin1_out  <= 1'b0;
         pin1_oe_b <= 1'b1;
         pin2_out  <= 1'b0;
         pin2_oe_b <= 1'b1;
      end else begin
         pin1_out  <= gpio_out[0];
         pin1_oe_b <= ~gpio_dir[0];
         pin2_out  <= tx_pin_func ? transmit_bit_latch : gpio_out[1];
         pin2_oe_b <= ~(tx_pin_func | gpio_dir[1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_count_wraps: assert property (
      counting & ~load_any & (count == `ETT_CNT_TOP) |=> carry_flag)
      else $error("top count did not raise carry flag");

   a_gated_source: assert property (
      (clk_sel == ETT_SRC_GATED) & ~timer_input_pin |-> ~tick)
      else $error("gated source ticked with pin low");

   a_load_preload: assert property (
      load_pulse |=> count == $past(preload))
      else $error("load did not take pre-load");

   a_write_loads: assert property (
      wr_cnt |=> count == $past(preload))
      else $error("counter write did not load");

   a_preload_store: assert property (
      wr_pre |=> (preload == $past(wb_dat_i[7:0])) ##1 $stable(preload) or wr_pre)
      else $error("pre-load not stored");

   a_count_step: assert property (
      counting & ~load_any & (count != `ETT_CNT_TOP) |=> count == $past(count) + `ETT_CNT_STEP)
      else $error("count did not step by one");

   a_count_hold: assert property (
      ~counting & ~load_any |=> $stable(count))
      else $error("count moved while idle");

   a_wait_idle: assert property (
      (state == ETT_WAIT) & ~load_any & ~wr_ctrl |=> $stable(count))
      else $error("count moved before start edge");

   a_start_run: assert property (
      (state == ETT_WAIT) & start_edge & ~wr_ctrl |=> state == ETT_RUN)
      else $error("start edge did not begin run");

   a_rx_sample: assert property (
      carry |=> receive_bit_latch == $past(timer_input_pin))
      else $error("receive latch missed sample");

   a_tx_shift: assert property (
      carry |=> transmit_bit_latch == $past(tx_pending))
      else $error("transmit latch not clocked");

   a_tx_pin: assert property (
      tx_pin_func & carry |=> ##1 pin2_out == $past(tx_pending, 2))
      else $error("serial pin not driven");

   a_pin2_enable: assert property (
      tx_pin_func |=> ~pin2_oe_b)
      else $error("serial pin not enabled");

   a_aux_tick: assert property (
      (clk_sel == ETT_SRC_AUX) & ~$rose(aux_clock) |-> ~tick)
      else $error("aux tick without aux edge");

   a_carry_reload: assert property (
      carry |=> count == $past(preload))
      else $error("carry did not reload");

   c_carry_run: cover property (carry & (state == ETT_RUN));
   c_start_seen: cover property ((state == ETT_WAIT) ##1 (state == ETT_RUN));
   c_aux_carry: cover property (carry & (clk_sel == ETT_SRC_AUX));
   c_flag_race: cover property (carry & wr_ser & wb_dat_i[`ETT_SER_CARRY]);

endmodule // ett_timer
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ett_defines.svh"
module tb_top;
   import ett_pkg::*;
   logic clock, rst_b, wb_cyc, wb_stb, wb_we, aux, pgo, pmode, wb_ack;
   logic [7:0]  wb_adr, pdata, d0, d1;
   logic [31:0] wb_dat_w, wb_dat_r, q, q2;
   logic pin1_out, pin1_oe_b, pin2_out, pin2_oe_b, p_busy, p_drive, p_level;
   wire  logic  pin1_w, pin2_w;
   int          miscompares = 0, n_checks = 0, n, k, s, b;
   logic [9:0]  tx;
   logic [8:0]  rx_exp;
   // pull-ups on both port pins
   assign pin1_w = !pin1_oe_b ? pin1_out : (p_drive ? p_level : 1'b1);
   assign pin2_w = !pin2_oe_b ? pin2_out : 1'b1;
   ett_timer i_ett_timer (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
      .aux_clock(aux), .pin1_in(pin1_w), .pin1_out(pin1_out), .pin1_oe_b(pin1_oe_b), .pin2_in(pin2_w),
      .pin2_out(pin2_out), .pin2_oe_b(pin2_oe_b));
   ett_peer i_ett_peer (.clock(clock), .rst_b(rst_b), .go(pgo), .pulse_mode(pmode), .data(pdata),
      .period(16'h0040), .busy(p_busy), .drive(p_drive), .level(p_level));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // hold the request until ack is sampled high
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int t;
      t = 0;
      wb_cyc   <= 1'b1;
      wb_stb   <= 1'b1;
      wb_we    <= we;
      wb_adr   <= a;
      wb_dat_w <= d;
      do begin
         @(posedge clock);
         t++;
      end while (wb_ack !== 1'b1 && t < 20);
      r = wb_dat_r;
      if (t >= 20) begin
         miscompares++;
         $display("[ERR] %0t no bus answer", $time);
      end
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   function automatic logic [31:0] exp_ticks(input int src, input int kk, input logic high);
      return (src == 3 && !high) ? 32'h0 : 32'(kk);
   endfunction
   function automatic logic [31:0] exp_gpio(input logic [3:0] g);
      return {26'h0, g[3] ? g[1] : 1'b1, g[2] ? g[0] : 1'b1, g};
   endfunction
   // counts gained between enable and disable, k ticks of the chosen source
   task automatic meas(input logic [1:0] src, input int kk, output logic [7:0] d);
      logic [31:0] r;
      int t;
      wr(`ETT_OFS_COUNT, 32'h0);
      wr(`ETT_OFS_CTRL, {29'h0, 1'b1, src});
      if (src == 2'd1) begin
         // aux clock far slower than the master clock
         repeat (kk) begin
            aux <= 1'b1;
            repeat (4) @(posedge clock);
            aux <= 1'b0;
            repeat (4) @(posedge clock);
         end
      end else if (src == 2'd2 && kk > 0) begin
         pmode <= 1'b1;
         pdata <= 8'(kk);
         pgo   <= 1'b1;
         @(posedge clock);
         pgo <= 1'b0;
         @(posedge clock);
         t = 0;
         while (p_busy && t < 500) begin
            @(posedge clock);
            t++;
         end
      end else begin
         repeat (kk) @(posedge clock);
      end
      repeat (6) @(posedge clock);
      wr(`ETT_OFS_CTRL, {30'h0, src});
      rd(`ETT_OFS_COUNT, r);
      d = r[7:0] - 8'h10;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge clock);
      miscompares++;
      end_of_test();
   end
   initial begin
      {wb_cyc, wb_stb, wb_we, aux, pgo, pmode} = 6'h00;
      wb_adr   = 8'h00;
      wb_dat_w = 32'h0;
      pdata    = 8'h00;
      rst_b    = 1'b0;
      void'($urandom(16));
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      rd(`ETT_OFS_CTRL, q);    chk(q, 32'h0, "ctrl reset");
      rd(`ETT_OFS_PRELOAD, q); chk(q, 32'h0, "preload reset");
      rd(`ETT_OFS_SERIAL, q);  chk(q, 32'h3, "serial reset");
      rd(`ETT_OFS_GPIO, q);    chk(q, 32'h30, "gpio reset");
      wr(8'h14, 32'hFF);
      rd(8'h14, q);            chk(q, 32'h0, "unmapped read");
      // buffered pre-load, load pulse and count write
      q2 = $urandom();
      wr(`ETT_OFS_PRELOAD, q2);
      rd(`ETT_OFS_PRELOAD, q); chk(q, {24'h0, q2[7:0]}, "preload rw");
      wr(`ETT_OFS_CTRL, 32'h20);
      rd(`ETT_OFS_COUNT, q);   chk(q, {24'h0, q2[7:0]}, "load pulse");
      rd(`ETT_OFS_CTRL, q);    chk(q, 32'h0, "load self clears");
      // new value buffered until the next load
      wr(`ETT_OFS_PRELOAD, {24'h0, ~q2[7:0]});
      rd(`ETT_OFS_COUNT, q);   chk(q, {24'h0, q2[7:0]}, "count held");
      wr(`ETT_OFS_COUNT, $urandom());
      rd(`ETT_OFS_COUNT, q);   chk(q, {24'h0, ~q2[7:0]}, "count write");
      // every clock source, then the gated one with the pin low
      wr(`ETT_OFS_PRELOAD, 32'h10);
      for (s = 0; s < 5; s++) begin
         k = 1 + $urandom_range(11);
         if (s == 4) wr(`ETT_OFS_GPIO, 32'h4);
         meas(s < 4 ? 2'(s) : 2'd3, 0, d0);
         meas(s < 4 ? 2'(s) : 2'd3, k, d1);
         chk({24'h0, 8'(d1 - d0)}, exp_ticks(s < 4 ? s : 3, k, s < 4), "count step");
      end
      rd(`ETT_OFS_COUNT, q);
      repeat (7) @(posedge clock);
      rd(`ETT_OFS_COUNT, q2);  chk(q2, q, "disabled hold");
      // shared pins under software control, txpin off
      for (s = 0; s < 4; s++) begin
         q2 = {28'h0, 2'(s), 2'($urandom())};
         wr(`ETT_OFS_GPIO, q2);
         // pins are registered one edge after the write lands
         @(posedge clock);
         chk({30'h0, pin1_oe_b, pin2_oe_b}, {30'h0, ~q2[2], ~q2[3]}, "pin enables");
         chk({30'h0, pin1_out, pin2_out}, {30'h0, q2[0], q2[1]}, "pin outputs");
         rd(`ETT_OFS_GPIO, q);  chk(q, exp_gpio(q2[3:0]), "pin levels");
      end
      wr(`ETT_OFS_GPIO, 32'h0);
      // serial frame: start detect, receive sampling, transmit bits
      tx    = 10'($urandom());
      pdata = 8'($urandom());
      pmode <= 1'b0;
      wr(`ETT_OFS_PRELOAD, 32'hC0);
      wr(`ETT_OFS_COUNT, 32'h0);
      wr(`ETT_OFS_SERIAL, {29'h0, 1'b1, tx[0], 1'b0});
      wr(`ETT_OFS_CTRL, 32'h1C);
      repeat (10) @(posedge clock);
      rd(`ETT_OFS_CTRL, q);    chk(q, 32'h5C, "waiting for start");
      rd(`ETT_OFS_COUNT, q);   chk(q, 32'hC0, "idle before start");
      rx_exp = {pdata, 1'b0};
      pgo <= 1'b1;
      @(posedge clock);
      pgo <= 1'b0;
      for (b = 1; b <= 9; b++) begin
         n = 0;
         do begin
            rd(`ETT_OFS_SERIAL, q);
            n++;
         end while (q[2] !== 1'b1 && n < 100);
         chk({31'h0, q[2]}, 32'h1, "carry flag");
         chk({31'h0, q[0]}, {31'h0, rx_exp[b-1]}, "rx bit");
         chk({31'h0, pin2_out}, {31'h0, tx[b-1]}, "tx pin");
         if (b == 1) begin
            rd(`ETT_OFS_CTRL, q2); chk(q2, 32'h1C, "running");
         end
         wr(`ETT_OFS_SERIAL, {29'h0, 1'b1, tx[b], 1'b0});
      end
      wr(`ETT_OFS_CTRL, 32'h0);
      rd(`ETT_OFS_SERIAL, q);  chk({31'h0, q[2]}, 32'h0, "flag cleared");
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
